// File: src/csd_channel.sv
/*
  One codec slot DMA channel: configuration registers on Avalon-MM, and
  the byte mover between the endpoint buffer and the codec slot registers
  through a small FIFO.
  Assumes the codec port pulses a slot strobe with the slot number, and
  that both data partners use valid/ready handshakes on the same clock.
*/
// Function
// - channel works on slots and endpoint only while the enable bit is one
// - bit 6 switches circular buffering for this channel alone
// - circular buffer bit goes to the buffer manager only, not to the transfer logic
// - control bits 5 and 4 read zero and ignore writes
// - control bit 3 selects IN endpoint when one, OUT when zero
// - control bits 2:0 give the endpoint number in binary
// - fourteen-bit slot mask split over low byte and high bits 5:0
// - slots whose mask bit is one move data, others are ignored
// - IN moves codec data to the buffer, OUT moves buffer data out
// - high bits 7:6 give one to four bytes per selected slot
`timescale 1ns/100ps

module csd_channel
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  // register bus
  input wire logic [csd_pkg::CSD_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [csd_pkg::CSD_DATA_W-1:0] I_AVS_WRITEDATA,
  input wire logic [csd_pkg::CSD_BE_W-1:0] I_AVS_BYTEENABLE,
  output logic [csd_pkg::CSD_DATA_W-1:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // configuration towards buffer manager and codec port
  output csd_pkg::csd_ep_cfg_s O_EP_CFG,
  output csd_pkg::csd_slot_cfg_s O_SLOT_CFG,
  output logic O_BUSY,
  // codec port slot timing
  input wire logic I_SLOT_STROBE,
  input wire logic [csd_pkg::CSD_SLOT_W-1:0] I_SLOT_NUM,
  // codec receive bytes (IN direction)
  input wire logic I_CODEC_RX_VALID,
  input wire logic [csd_pkg::CSD_BYTE_W-1:0] I_CODEC_RX_DATA,
  output logic O_CODEC_RX_READY,
  // codec transmit bytes (OUT direction)
  output logic O_CODEC_TX_VALID,
  output logic [csd_pkg::CSD_BYTE_W-1:0] O_CODEC_TX_DATA,
  input wire logic I_CODEC_TX_READY,
  // endpoint buffer reads (OUT direction)
  input wire logic I_BUF_RD_VALID,
  input wire logic [csd_pkg::CSD_BYTE_W-1:0] I_BUF_RD_DATA,
  output logic O_BUF_RD_READY,
  // endpoint buffer writes (IN direction)
  output logic O_BUF_WR_VALID,
  output logic [csd_pkg::CSD_BYTE_W-1:0] O_BUF_WR_DATA,
  input wire logic I_BUF_WR_READY
);

  import csd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] control_q;
  logic [7:0] mask_low_q;
  logic [7:0] mask_high_q;
  logic overrun_q;
  logic wait_q;
  logic [CSD_DATA_W-1:0] rdata_q;
  logic [CSD_DATA_W-1:0] rdata_d;
  logic bus_req;
  logic bus_done;
  logic wr_lane0;
  logic sel_control;
  logic sel_mask_low;
  logic sel_mask_high;
  logic sel_status;

  logic ch_enable;
  logic ch_wrap;
  csd_dir_e ch_dir;
  logic [CSD_SLOTS-1:0] slot_mask;
  csd_bps_e bps;

  logic [CSD_SLOTS-1:0] slot_hit_vec;
  logic slot_hit;
  logic slot_take;
  logic [CSD_LEFT_W-1:0] left_q;
  logic [CSD_LEFT_W-1:0] bps_count;

  logic rx_ready_q;
  logic rd_ready_q;
  logic tx_valid_q;
  logic wr_valid_q;
  logic [CSD_BYTE_W-1:0] out_data_q;
  logic rx_take;
  logic rd_take;
  logic src_byte;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [CSD_BYTE_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [CSD_BYTE_W-1:0] fifo_out_data;
  logic stage_free;
  logic flush;

  logic [7:0] status_byte;
  logic [CSD_SLOTS-1:0] slot_mask_q;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign bus_done = bus_req & ~wait_q;
  assign wr_lane0 = I_AVS_WRITE & bus_done & I_AVS_BYTEENABLE[0];
  assign sel_control = I_AVS_ADDRESS == {CSD_IDX_CONTROL, 2'b00};
  assign sel_mask_low = I_AVS_ADDRESS == {CSD_IDX_MASK_LOW, 2'b00};
  assign sel_mask_high = I_AVS_ADDRESS == {CSD_IDX_MASK_HIGH, 2'b00};
  assign sel_status = I_AVS_ADDRESS == {CSD_IDX_STATUS, 2'b00};

  assign ch_enable = control_q[CSD_CTL_ENABLE];
  assign ch_wrap = control_q[CSD_CTL_WRAP];
  assign ch_dir = csd_dir_e'(control_q[CSD_CTL_DIR]);
  assign bps = csd_bps_e'(mask_high_q[CSD_MH_BPS_HI:CSD_MH_BPS_LO]);
  assign slot_mask = {mask_high_q[CSD_MH_MASK_HI:CSD_MH_MASK_LO],
                      mask_low_q};

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the access completes

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      wait_q <= 1'b1;
    end
    else if (bus_req && wait_q)
    begin
      wait_q <= 1'b0;
    end
    else
    begin
      wait_q <= 1'b1;
    end
  end

  always_comb
  begin
    rdata_d = '0;
    if (sel_control)
    begin
      rdata_d[7:0] = control_q;
    end
    else if (sel_mask_low)
    begin
      rdata_d[7:0] = mask_low_q;
    end
    else if (sel_mask_high)
    begin
      rdata_d[7:0] = mask_high_q;
    end
    else if (sel_status)
    begin
      rdata_d[7:0] = status_byte;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      rdata_q <= '0;
    end
    else if (I_AVS_READ && wait_q)
    begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      control_q <= CSD_RST_CONTROL;
    end
    else if (wr_lane0 && sel_control)
    begin
      control_q <= I_AVS_WRITEDATA[7:0];
      control_q[CSD_CTL_RSVD_HI] <= 1'b0;
      control_q[CSD_CTL_RSVD_LO] <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      mask_low_q <= CSD_RST_MASK_LOW;
    end
    else if (wr_lane0 && sel_mask_low)
    begin
      mask_low_q <= I_AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      mask_high_q <= CSD_RST_MASK_HIGH;
    end
    else if (wr_lane0 && sel_mask_high)
    begin
      mask_high_q <= I_AVS_WRITEDATA[7:0];
    end
  end

  // slot strobe during a slot still in progress; a new event beats the clear
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      overrun_q <= 1'b0;
    end
    else if (slot_hit && left_q != '0)
    begin
      overrun_q <= 1'b1;
    end
    else if (wr_lane0 && sel_status && I_AVS_WRITEDATA[CSD_ST_OVERRUN])
    begin
      overrun_q <= 1'b0;
    end
  end

  always_comb
  begin
    status_byte = '0;
    status_byte[CSD_ST_BUSY] = left_q != '0;
    status_byte[CSD_ST_EMPTY] = ~fifo_out_valid & ~tx_valid_q & ~wr_valid_q;
    status_byte[CSD_ST_FULL] = ~fifo_in_ready;
    status_byte[CSD_ST_OVERRUN] = overrun_q;
    status_byte[CSD_ST_LEFT_HI:CSD_ST_LEFT_LO] = left_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot selection, one term per slot

  genvar s;
  generate
    for (s = 0; s < CSD_SLOTS; s++)
    begin : g_slot
      assign slot_hit_vec[s] = slot_mask[s] &&
        (I_SLOT_NUM == CSD_SLOT_W'(s));
    end
  endgenerate

  assign slot_hit = ch_enable & I_SLOT_STROBE & (|slot_hit_vec);
  assign slot_take = slot_hit & (left_q == '0);
  assign bps_count = {1'b0, bps} + CSD_LEFT_W'(1);

  // bytes still to move in the current slot
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET || !ch_enable)
    begin
      left_q <= '0;
    end
    else if (slot_take)
    begin
      left_q <= bps_count;
    end
    else if (src_byte)
    begin
      left_q <= left_q - CSD_LEFT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source side: ready is offered every other cycle so that the room seen
  // in the fifo one cycle earlier still holds when the byte lands

  assign rx_take = rx_ready_q & I_CODEC_RX_VALID;
  assign rd_take = rd_ready_q & I_BUF_RD_VALID;
  assign src_byte = rx_take | rd_take;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      rx_ready_q <= 1'b0;
    end
    else
    begin
      rx_ready_q <= ch_enable && ch_dir == CSD_DIR_IN && fifo_in_ready &&
        left_q != '0 && !rx_ready_q && !slot_take;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      rd_ready_q <= 1'b0;
    end
    else
    begin
      rd_ready_q <= ch_enable && ch_dir == CSD_DIR_OUT && fifo_in_ready &&
        left_q != '0 && !rd_ready_q && !slot_take;
    end
  end

  assign fifo_in_valid = src_byte;
  assign fifo_in_data = rx_take ? I_CODEC_RX_DATA : I_BUF_RD_DATA;
  assign flush = ~ch_enable;

  csd_fifo
  #(
    .WIDTH(CSD_BYTE_W),
    .DEPTH(CSD_FIFO_DEPTH)
  )
  u_fifo
  (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_flush(flush),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sink side: one output stage steered by the direction bit

  assign stage_free = (~tx_valid_q | I_CODEC_TX_READY) &
    (~wr_valid_q | I_BUF_WR_READY);
  assign fifo_out_ready = stage_free & ch_enable;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET || !ch_enable)
    begin
      tx_valid_q <= 1'b0;
      wr_valid_q <= 1'b0;
    end
    else if (fifo_out_ready)
    begin
      tx_valid_q <= fifo_out_valid && ch_dir == CSD_DIR_OUT;
      wr_valid_q <= fifo_out_valid && ch_dir == CSD_DIR_IN;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      out_data_q <= '0;
    end
    else if (fifo_out_ready && fifo_out_valid)
    begin
      out_data_q <= fifo_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration copies for the buffer manager and codec port

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      O_EP_CFG <= '0;
    end
    else
    begin
      O_EP_CFG.channel_enable <= ch_enable;
      O_EP_CFG.circular_buffer_enable <= ch_wrap;
      O_EP_CFG.endpoint_direction <= ch_dir;
      O_EP_CFG.endpoint_number <=
        control_q[CSD_CTL_EP_HI:CSD_CTL_EP_LO];
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      slot_mask_q <= '0;
      O_SLOT_CFG <= '0;
      O_BUSY <= 1'b0;
    end
    else
    begin
      slot_mask_q <= slot_mask;
      O_SLOT_CFG.slot_mask <= slot_mask_q;
      O_SLOT_CFG.bytes_per_slot <= bps;
      O_BUSY <= left_q != '0 || tx_valid_q || wr_valid_q || fifo_out_valid;
    end
  end

  assign O_AVS_READDATA = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;
  assign O_CODEC_RX_READY = rx_ready_q;
  assign O_BUF_RD_READY = rd_ready_q;
  assign O_CODEC_TX_VALID = tx_valid_q;
  assign O_BUF_WR_VALID = wr_valid_q;
  assign O_CODEC_TX_DATA = out_data_q;
  assign O_BUF_WR_DATA = out_data_q;

endmodule

// File: src/csd_pkg.sv
/*
  Package of the codec slot DMA channel: register indices, field positions,
  reset values, enumerations and the packed structs carried on the ports.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package csd_pkg;

  // bus geometry
  localparam int CSD_ADDR_W = 18;
  localparam int CSD_DATA_W = 32;
  localparam int CSD_BE_W = 4;

  // register indices; byte address is four times the index
  localparam logic [15:0] CSD_IDX_MASK_HIGH = 16'hffe9;
  localparam logic [15:0] CSD_IDX_MASK_LOW = 16'hffea;
  localparam logic [15:0] CSD_IDX_CONTROL = 16'hffee;
  localparam logic [15:0] CSD_IDX_STATUS = 16'hffd0;

  // control register fields
  localparam int CSD_CTL_ENABLE = 7;
  localparam int CSD_CTL_WRAP = 6;
  localparam int CSD_CTL_RSVD_HI = 5;
  localparam int CSD_CTL_RSVD_LO = 4;
  localparam int CSD_CTL_DIR = 3;
  localparam int CSD_CTL_EP_HI = 2;
  localparam int CSD_CTL_EP_LO = 0;

  // slot mask high register fields
  localparam int CSD_MH_BPS_HI = 7;
  localparam int CSD_MH_BPS_LO = 6;
  localparam int CSD_MH_MASK_HI = 5;
  localparam int CSD_MH_MASK_LO = 0;

  // status register fields
  localparam int CSD_ST_BUSY = 0;
  localparam int CSD_ST_EMPTY = 1;
  localparam int CSD_ST_FULL = 2;
  localparam int CSD_ST_OVERRUN = 3;
  localparam int CSD_ST_LEFT_LO = 4;
  localparam int CSD_ST_LEFT_HI = 6;

  // reset values
  localparam logic [7:0] CSD_RST_CONTROL = 8'h00;
  localparam logic [7:0] CSD_RST_MASK_LOW = 8'h00;
  localparam logic [7:0] CSD_RST_MASK_HIGH = 8'h00;

  // datapath geometry
  localparam int CSD_SLOTS = 14;
  localparam int CSD_SLOT_W = 4;
  localparam int CSD_BYTE_W = 8;
  localparam int CSD_FIFO_DEPTH = 4;
  localparam int CSD_LEFT_W = 3;

  typedef enum logic [0:0]
  {
    CSD_DIR_OUT = 1'b0,
    CSD_DIR_IN = 1'b1
  } csd_dir_e;

  typedef enum logic [1:0]
  {
    CSD_BPS_ONE = 2'b00,
    CSD_BPS_TWO = 2'b01,
    CSD_BPS_THREE = 2'b10,
    CSD_BPS_FOUR = 2'b11
  } csd_bps_e;

  // endpoint side of the configuration, seen by the buffer manager
  typedef struct packed
  {
    logic channel_enable;
    logic circular_buffer_enable;
    csd_dir_e endpoint_direction;
    logic [2:0] endpoint_number;
  } csd_ep_cfg_s;

  // slot side of the configuration, seen by the codec port logic
  typedef struct packed
  {
    csd_bps_e bytes_per_slot;
    logic [CSD_SLOTS-1:0] slot_mask;
  } csd_slot_cfg_s;

endpackage

// File: src/csd_fifo.sv
/*
  Shift-register FIFO with valid/ready on both sides. The head entry is a
  flip-flop, so read data come straight out of a register.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps

module csd_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic full_q;
  logic empty_q;
  logic push;
  logic pop;

  assign o_in_ready = ~full_q;
  assign o_out_valid = ~empty_q;
  assign o_out_data = mem_q[0];
  assign push = i_in_valid & ~full_q;
  assign pop = ~empty_q & i_out_ready;

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = count_q + CW'(1);
    end
    else if (pop && !push)
    begin
      count_d = count_q - CW'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset || i_flush)
    begin
      count_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      count_q <= count_d;
      full_q <= (count_d == CW'(DEPTH));
      empty_q <= (count_d == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one entry per stage: shift down on pop, take new data at the tail
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      always_ff @(posedge i_clk)
      begin
        if (i_reset)
        begin
          mem_q[i] <= '0;
        end
        else if (pop)
        begin
          if (push && count_q == CW'(i + 1))
          begin
            mem_q[i] <= i_in_data;
          end
          else if (i < DEPTH - 1)
          begin
            mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
          end
        end
        else if (push && count_q == CW'(i))
        begin
          mem_q[i] <= i_in_data;
        end
      end
    end
  endgenerate

endmodule

// File: verif/csd_channel_assertions.sv
/*
  Port checker of csd_channel, bound to every instance.
  Assumes one bus request at a time and config changes while idle.
*/
`timescale 1ns/100ps

module csd_channel_assertions
import csd_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [csd_pkg::CSD_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [csd_pkg::CSD_DATA_W-1:0] I_AVS_WRITEDATA,
  input wire logic [csd_pkg::CSD_DATA_W-1:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire csd_pkg::csd_ep_cfg_s O_EP_CFG,
  input wire csd_pkg::csd_slot_cfg_s O_SLOT_CFG,
  input wire logic O_BUSY,
  input wire logic O_CODEC_RX_READY,
  input wire logic O_BUF_RD_READY,
  input wire logic O_CODEC_TX_VALID,
  input wire logic [csd_pkg::CSD_BYTE_W-1:0] O_CODEC_TX_DATA,
  input wire logic I_CODEC_TX_READY,
  input wire logic O_BUF_WR_VALID,
  input wire logic [csd_pkg::CSD_BYTE_W-1:0] O_BUF_WR_DATA,
  input wire logic I_BUF_WR_READY
);
  localparam logic [17:0] A_CTL = {CSD_IDX_CONTROL, 2'b00};
  localparam logic [17:0] A_HI = {CSD_IDX_MASK_HIGH, 2'b00};
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);
  wire logic done_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST;
  wire logic rdy = O_CODEC_RX_READY || O_BUF_RD_READY;

  ////////////////////////////////////////
  reset_clear_a: assert property ($fell(I_RESET) |->
    O_EP_CFG == 6'h00 && O_SLOT_CFG == 16'h0000 && O_AVS_WAITREQUEST)
    else $error("outputs not clear after reset");
  bus_wait_a: assert property ((I_AVS_READ || I_AVS_WRITE) &&
    O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("bus answer not one wait cycle");
  rsvd_zero_a: assert property (I_AVS_READ && !O_AVS_WAITREQUEST &&
    I_AVS_ADDRESS == A_CTL |-> O_AVS_READDATA[5:4] == 2'b00)
    else $error("reserved control bits not zero");
  ep_cfg_a: assert property (done_wr && I_AVS_ADDRESS == A_CTL |->
    ##3 O_EP_CFG == {$past(I_AVS_WRITEDATA[7:6], 3),
    $past(I_AVS_WRITEDATA[3:0], 3)}) else $error("ep config mismatch");
  bps_cfg_a: assert property (done_wr && I_AVS_ADDRESS == A_HI |->
    ##4 O_SLOT_CFG[15:8] == $past(I_AVS_WRITEDATA[7:0], 4))
    else $error("slot config high mismatch");
  ready_gap_a: assert property (rdy |=> !rdy)
    else $error("ready on two cycles running");
  dir_in_a: assert property (O_CODEC_RX_READY |-> !O_BUF_RD_READY &&
    O_EP_CFG.endpoint_direction == CSD_DIR_IN) else $error("rx in OUT");
  dir_out_a: assert property (O_BUF_RD_READY |->
    O_EP_CFG.endpoint_direction == CSD_DIR_OUT) else $error("rd in IN");
  idle_off_a: assert property (!O_EP_CFG.channel_enable [*3] |-> !rdy)
    else $error("ready while disabled");
  tx_hold_a: assert property (O_CODEC_TX_VALID && !I_CODEC_TX_READY |=>
    !O_EP_CFG.channel_enable || (O_CODEC_TX_VALID &&
    $stable(O_CODEC_TX_DATA))) else $error("tx byte not held");
  wr_hold_a: assert property (O_BUF_WR_VALID && !I_BUF_WR_READY |=>
    !O_EP_CFG.channel_enable || (O_BUF_WR_VALID &&
    $stable(O_BUF_WR_DATA))) else $error("wr byte not held");
  busy_flag_a: assert property (rdy || O_CODEC_TX_VALID ||
    O_BUF_WR_VALID |=> O_BUSY) else $error("busy low during transfer");
  cover property (done_wr && I_AVS_ADDRESS == A_CTL);
  cover property (O_BUF_WR_VALID && !I_BUF_WR_READY);
  cover property (O_CODEC_TX_VALID && I_CODEC_TX_READY);
endmodule

bind csd_channel csd_channel_assertions u_chk (.I_SYS_CLK(I_SYS_CLK),
  .I_RESET(I_RESET), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_EP_CFG(O_EP_CFG), .O_SLOT_CFG(O_SLOT_CFG), .O_BUSY(O_BUSY),
  .O_CODEC_RX_READY(O_CODEC_RX_READY), .O_BUF_RD_READY(O_BUF_RD_READY),
  .O_CODEC_TX_VALID(O_CODEC_TX_VALID), .O_CODEC_TX_DATA(O_CODEC_TX_DATA),
  .I_CODEC_TX_READY(I_CODEC_TX_READY), .O_BUF_WR_VALID(O_BUF_WR_VALID),
  .O_BUF_WR_DATA(O_BUF_WR_DATA), .I_BUF_WR_READY(I_BUF_WR_READY));

// File: verif/csd_partner.sv
/*
  Far-side model: a byte source counting up from BASE and a byte sink
  that keeps what it takes; both stall while i_stall is high.
  Assumes valid/ready on the channel's clock.
*/
`timescale 1ns/100ps

module csd_partner
#(
  parameter logic [7:0] BASE = 8'h00
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_stall,
  output logic o_src_valid,
  output logic [7:0] o_src_data,
  input wire logic i_src_ready,
  input wire logic i_snk_valid,
  input wire logic [7:0] i_snk_data,
  output logic o_snk_ready
);
  logic [7:0] sent_q;
  logic [7:0] got[$];
  assign o_src_valid = !i_stall;
  // no valid byte: show the inverse so stale data never matches
  assign o_src_data = i_stall ? ~(BASE + sent_q) : BASE + sent_q;
  assign o_snk_ready = !i_stall;
  always @(posedge i_clk)
  begin
    if (i_reset)
      sent_q <= 8'h00;
    else if (i_src_ready && o_src_valid)
      sent_q <= sent_q + 8'h01;
    if (!i_reset && i_snk_valid && o_snk_ready)
      got.push_back(i_snk_data);
  end
endmodule

// File: verif/csd_channel_tb.sv
/*
  Self-checking bench of csd_channel with a queue model of the bytes.
  Assumes csd_partner on codec and buffer sides, and the bound checker.
*/
`timescale 1ns/100ps

`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end

module csd_channel_tb;
  import csd_pkg::*;
  logic clk, rst, rd, wr, stb, st_c, st_b, heavy, dir, en;
  logic [17:0] adr;
  logic [31:0] wd, rdata, rng, v, sr;
  logic [3:0] be, num;
  logic [7:0] r, ctl, tx_d, wr_d, rx_d, brd_d;
  logic [13:0] msk;
  logic [1:0] bps;
  logic [2:0] ep;
  logic wreq, busy, rx_rdy, tx_v, rd_rdy, wr_v, rx_v, tx_rdy, brd_v, bwr_rdy;
  csd_ep_cfg_s ep_cfg;
  csd_slot_cfg_s slot_cfg;
  logic [7:0] exp_b[$], exp_c[$];
  int n_mismatch, samples_checked, cod_n, buf_n;

  csd_channel dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .O_EP_CFG(ep_cfg), .O_SLOT_CFG(slot_cfg), .O_BUSY(busy),
    .I_SLOT_STROBE(stb), .I_SLOT_NUM(num), .I_CODEC_RX_VALID(rx_v),
    .I_CODEC_RX_DATA(rx_d), .O_CODEC_RX_READY(rx_rdy),
    .O_CODEC_TX_VALID(tx_v), .O_CODEC_TX_DATA(tx_d),
    .I_CODEC_TX_READY(tx_rdy), .I_BUF_RD_VALID(brd_v),
    .I_BUF_RD_DATA(brd_d), .O_BUF_RD_READY(rd_rdy), .O_BUF_WR_VALID(wr_v),
    .O_BUF_WR_DATA(wr_d), .I_BUF_WR_READY(bwr_rdy));
  csd_partner #(.BASE(8'h40)) p_cod (.i_clk(clk), .i_reset(rst),
    .i_stall(st_c), .o_src_valid(rx_v), .o_src_data(rx_d),
    .i_src_ready(rx_rdy), .i_snk_valid(tx_v), .i_snk_data(tx_d),
    .o_snk_ready(tx_rdy));
  csd_partner #(.BASE(8'h90)) p_buf (.i_clk(clk), .i_reset(rst),
    .i_stall(st_b), .o_src_valid(brd_v), .o_src_data(brd_d),
    .i_src_ready(rd_rdy), .i_snk_valid(wr_v), .i_snk_data(wr_d),
    .o_snk_ready(bwr_rdy));

  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [15:0] ix,
                     input logic [7:0] d, output logic [7:0] q);
    adr <= {ix, 2'b00};
    wd <= {24'h000000, d};
    be <= 4'hf;
    rd <= !w;
    wr <= w;
    // the wait ends when wreq drops; only the watchdog ends a wait that gets no answer
    do
    begin
      @(posedge clk);
    end
    while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic slot(input int s);
    stb <= 1'b1;
    num <= s[3:0];
    @(posedge clk);
    stb <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0)
      @(posedge clk);
  endtask

  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the heavily stalled side is the sink of the current direction
  always @(posedge clk)
  begin
    sr = xs();
    st_c <= (heavy && !dir) ? sr[1:0] != 2'b00 : sr[1:0] == 2'b00;
    st_b <= (heavy && dir) ? sr[3:2] != 2'b00 : sr[3:2] == 2'b00;
  end

  initial
  begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    rng = 32'hcd3a;
    {rst, rd, wr, stb, heavy, dir} = 6'b100000;
    {adr, wd, be, num} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("ep cfg", 6'h00, ep_cfg);
    `CHK("slot cfg", 16'h0000, slot_cfg);
    foreach (exp_b[i]) exp_b.delete();
    bus(1'b0, CSD_IDX_MASK_HIGH, 8'h00, r);
    `CHK("mask high", CSD_RST_MASK_HIGH, r);
    bus(1'b0, CSD_IDX_MASK_LOW, 8'h00, r);
    `CHK("mask low", CSD_RST_MASK_LOW, r);
    bus(1'b0, CSD_IDX_CONTROL, 8'h00, r);
    `CHK("control", CSD_RST_CONTROL, r);
    bus(1'b1, CSD_IDX_CONTROL, 8'h7f, r);
    bus(1'b0, CSD_IDX_CONTROL, 8'h00, r);
    `CHK("control rsvd", 8'h4f, r);
    bus(1'b0, 16'h0100, 8'h00, r);
    `CHK("unmapped", 8'h00, r);
    for (int t = 0; t < 8; t++)
    begin
      v = xs();
      dir = t[0];
      bps = t[2:1];
      heavy = t[1];
      ep = (v[2:0] == 3'h0) ? 3'h1 : v[2:0];
      msk = v[21:8];
      en = (t != 7);
      // all endpoints here are isochronous, so wrap may be set
      ctl = {1'b0, v[3], 2'b00, dir, ep};
      bus(1'b1, CSD_IDX_CONTROL, ctl, r);
      bus(1'b1, CSD_IDX_MASK_LOW, msk[7:0], r);
      bus(1'b1, CSD_IDX_MASK_HIGH, {bps, msk[13:8]}, r);
      ctl[7] = en;
      bus(1'b1, CSD_IDX_CONTROL, ctl, r);
      bus(1'b0, CSD_IDX_CONTROL, 8'h00, r);
      `CHK("control", ctl, r);
      bus(1'b0, CSD_IDX_MASK_LOW, 8'h00, r);
      `CHK("mask low", msk[7:0], r);
      bus(1'b0, CSD_IDX_MASK_HIGH, 8'h00, r);
      `CHK("mask high", {bps, msk[13:8]}, r);
      repeat (4) @(posedge clk);
      `CHK("ep cfg", {en, ctl[6], dir, ep}, ep_cfg);
      `CHK("slot cfg", {bps, msk}, slot_cfg);
      for (int s = 0; s < CSD_SLOTS; s++)
      begin
        slot(s);
        for (int k = 0; en && msk[s] && k <= int'(bps); k++)
          if (dir)
            exp_b.push_back(8'h40 + 8'(cod_n++));
          else
            exp_c.push_back(8'h90 + 8'(buf_n++));
      end
    end
    // a strobe while the slot is still busy sets the sticky overrun flag
    bus(1'b1, CSD_IDX_MASK_LOW, 8'h01, r);
    bus(1'b1, CSD_IDX_MASK_HIGH, 8'h00, r);
    bus(1'b1, CSD_IDX_CONTROL, 8'h89, r);
    stb <= 1'b1;
    num <= 4'h0;
    @(posedge clk);
    slot(0);
    exp_b.push_back(8'h40 + 8'(cod_n++));
    bus(1'b0, CSD_IDX_STATUS, 8'h00, r);
    `CHK("status", 8'h0a, r);
    bus(1'b1, CSD_IDX_STATUS, 8'h08, r);
    bus(1'b0, CSD_IDX_STATUS, 8'h00, r);
    `CHK("status clr", 8'h02, r);
    heavy = 1'b0;
    repeat (100) @(posedge clk);
    `CHK("buf count", exp_b.size(), p_buf.got.size());
    `CHK("codec count", exp_c.size(), p_cod.got.size());
    foreach (exp_b[i])
      if (i < p_buf.got.size())
        `CHK("buf byte", exp_b[i], p_buf.got[i]);
    foreach (exp_c[i])
      if (i < p_cod.got.size())
        `CHK("codec byte", exp_c[i], p_cod.got[i]);
    report_and_stop();
  end
endmodule
